// ==== inc/capture_vint_consts.svh ====
// Offsets, write masks, reset values and counts of the capture
// vertical interrupt and DMA threshold block.
// Assumes a 5-bit byte address on the register bus.
`ifndef CAPTURE_VINT_CONSTS_SVH
`define CAPTURE_VINT_CONSTS_SVH
`define OFS_VINT_CTRL  5'h00
`define OFS_THRESHOLD  5'h04
`define OFS_IRQ_STATUS 5'h08
`define OFS_IRQ_MASK   5'h0c
`define OFS_LINE_STAT  5'h10
`define OFS_CHAN_CFG   5'h14
`define VINT_WMASK     32'hcfff8fff
`define THR_WMASK      32'h03ff03ff
`define IRQ_WMASK      32'h00000007
`define CFG_WMASK      32'h00000001
`define VINT_RESET     32'h00000000
`define THR_RESET      32'h00000000
`define IRQ_RESET      3'h0
`define CFG_RESET      1'h0
`define IRQ_BIT_VINT   0
`define IRQ_BIT_YEVT   1
`define IRQ_BIT_CEVT   2
`define SAMPLES_DW_8   5'h08
`define SAMPLES_DW_16  5'h04
`define COUNT_MAX      14'h3fff
`endif

// ==== inc/capture_vint_pkg.sv ====
// Types of the capture vertical interrupt and DMA threshold block.
// Field layouts follow the register map bit for bit.
package capture_vint_pkg;
  typedef enum logic [3:0] {
    MODE_BT656     = 4'b0001,
    MODE_YC        = 4'b0010,
    MODE_RAW       = 4'b0100,
    MODE_TRANSPORT = 4'b1000
  } capture_mode_t;

  typedef struct packed {
    logic        field2_irq_enable;
    logic        sync_clear_in_second_field;
    logic [1:0]  rsv_hi;
    logic [11:0] field2_irq_line;
    logic        field1_irq_enable;
    logic [2:0]  rsv_lo;
    logic [11:0] field1_irq_line;
  } vint_ctrl_t;

  typedef struct packed {
    logic [5:0] rsv_hi;
    logic [9:0] field2_dma_threshold;
    logic [5:0] rsv_lo;
    logic [9:0] field1_dma_threshold;
  } threshold_t;

  typedef struct packed {
    logic clk;
    logic line_end;
    logic vreset;
    logic sample_wr;
    logic field2;
  } link_t;

  typedef struct packed {
    link_t       sync1;
    link_t       sync2;
    logic        clk_prev;
    logic [11:0] line_counter;
    vint_ctrl_t  vint_ctrl;
    threshold_t  thr;
    logic        second_threshold_enable;
    logic [2:0]  irq_status;
    logic [2:0]  irq_mask;
    logic        irq;
    logic        ack;
    logic [31:0] rdata;
    logic [13:0] y_count;
    logic [13:0] c_count;
    logic        pair;
    logic        y_armed;
    logic        c_armed;
    logic        vint_pulse;
    logic        sync_clear;
    logic        y_event;
    logic        c_event;
  } state_t;
endpackage

// ==== rtl/capture_vint_and_dma_threshold.sv ====
// Vertical line interrupt, frame-sync clear and DMA threshold events
// of one video capture channel, with an Avalon-MM register slave.
// Assumes link signals change on falling link_clk edges, slow enough
// for sys_clk to see each level, and dma_first_read from sys_clk logic.
//
// Operation
// R01: Interrupt at end of matching line
// R02: Separate interrupt enables per field
// R03: Select 0 clears sync in field 1
// R04: Select 1 clears sync in field 2
// R05: Two 12-bit interrupt line fields
// R06: Reserved bits read zero, ignore writes
// R07: Interrupts only in BT.656 or Y/C
// R08: DMA event when field-1 threshold reached
// R09: Block events until first FIFO read
// R10: Pixel pair gives one chroma byte each
// R11: Threshold unit is 8 pixels, 8-bit
// R12: Chroma trigger is half the threshold
// R13: Raw unit 8 or 4 samples
// R14: Transport unit is 8 one-byte samples
// R15: Field-2 threshold only when enabled
// R16: Count data entering the FIFO
// R17: Field-2 threshold unused in raw, transport
// R18: Vertical event resets line counter
// R19: Interrupt is a one-cycle pulse
`timescale 1ns/100ps
`include "capture_vint_consts.svh"

module capture_vint_and_dma_threshold (
  input  wire logic                           sys_clk,
  input  wire logic                           sys_rst,
  input  wire logic [4:0]                     avs_address,
  input  wire logic                           avs_read,
  input  wire logic                           avs_write,
  input  wire logic [31:0]                    avs_writedata,
  input  wire logic [3:0]                     avs_byteenable,
  output logic      [31:0]                    avs_readdata,
  output logic                                avs_waitrequest,
  input  wire capture_vint_pkg::capture_mode_t cap_mode,
  input  wire logic                           raw_16bit,
  input  wire capture_vint_pkg::link_t        link,
  input  wire logic                           dma_first_read,
  output logic                                vint_pulse,
  output logic                                frame_sync_clear,
  output logic                                luma_dma_event,
  output logic                                chroma_dma_event,
  output logic                                irq
);
  capture_vint_pkg::state_t s;
  capture_vint_pkg::state_t next_s;

  logic        rise;
  logic        bt_yc;
  logic        fld2;
  logic [11:0] cur_line;
  logic        line_hit;
  logic [9:0]  thr_sel;
  logic [4:0]  unit;
  logic [13:0] level;
  logic [13:0] c_level;
  logic        req;

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] wd,
                                        input logic [3:0]  be,
                                        input logic [31:0] wmask);
    logic [31:0] m;
    m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}} & wmask;
    merge = (old & ~m) | (wd & m);
  endfunction

  function automatic logic [13:0] bump(input logic [13:0] v);
    bump = (v == `COUNT_MAX) ? v : v + 14'h1;
  endfunction

  // Link clock edge, seen on synchronised copies only
  assign rise  = s.sync2.clk & ~s.clk_prev;
  assign bt_yc = (cap_mode == capture_vint_pkg::MODE_BT656) ||
                 (cap_mode == capture_vint_pkg::MODE_YC);
  assign fld2  = s.sync2.field2;
  assign cur_line = fld2 ? s.vint_ctrl.field2_irq_line
                         : s.vint_ctrl.field1_irq_line;
  // Compare at the end of the line, before the counter moves on
  assign line_hit = rise && s.sync2.line_end && !s.sync2.vreset &&
                    bt_yc && (s.line_counter == cur_line); // see R01 see R07
  // Field-2 threshold only in BT.656/Y/C with its enable set
  assign thr_sel = (bt_yc && fld2 && s.second_threshold_enable)
                 ? s.thr.field2_dma_threshold
                 : s.thr.field1_dma_threshold; // see R15 see R17
  assign unit  = (cap_mode == capture_vint_pkg::MODE_RAW && raw_16bit)
               ? `SAMPLES_DW_16 : `SAMPLES_DW_8; // see R11 see R13 see R14
  // Both factors widened first so the product keeps its upper bits
  assign level   = 14'(thr_sel) * 14'(unit);
  assign c_level = level >> 1; // see R12
  assign req   = avs_read | avs_write;

  always_comb begin
    next_s = s;
    next_s.sync1 = link;
    next_s.sync2 = s.sync1;
    next_s.clk_prev = s.sync2.clk;
    next_s.vint_pulse = 1'b0;
    next_s.sync_clear = 1'b0;
    next_s.y_event = 1'b0;
    next_s.c_event = 1'b0;

    if (rise) begin
      if (s.sync2.vreset) begin
        next_s.line_counter = 12'h000; // see R18
      end else if (s.sync2.line_end) begin
        next_s.line_counter = s.line_counter + 12'h001;
      end
    end
    if (line_hit) begin
      next_s.vint_pulse = fld2 ? s.vint_ctrl.field2_irq_enable
                               : s.vint_ctrl.field1_irq_enable; // see R02 see R19
      next_s.sync_clear = (fld2 == s.vint_ctrl.sync_clear_in_second_field); // see R03 see R04
    end

    // Data counted as it is written into the FIFOs
    if (rise && s.sync2.sample_wr) begin
      next_s.y_count = bump(s.y_count); // see R16
      next_s.pair = ~s.pair;
      if (bt_yc && s.pair) begin
        next_s.c_count = bump(s.c_count); // see R10
      end
    end
    if (dma_first_read) begin
      next_s.y_armed = 1'b1; // see R09
      next_s.c_armed = 1'b1;
    end
    if (next_s.y_armed && level != 14'h0 && next_s.y_count >= level) begin
      next_s.y_event = 1'b1; // see R08
      next_s.y_count = next_s.y_count - level;
      next_s.y_armed = 1'b0; // see R09
    end
    if (bt_yc && next_s.c_armed && c_level != 14'h0 &&
        next_s.c_count >= c_level) begin
      next_s.c_event = 1'b1; // see R12
      next_s.c_count = next_s.c_count - c_level;
      next_s.c_armed = 1'b0;
    end

    // Register slave: one wait cycle, then the access completes
    if (req && !s.ack) begin
      next_s.ack = 1'b1;
      if (avs_address == `OFS_VINT_CTRL) begin
        next_s.rdata = s.vint_ctrl & `VINT_WMASK; // see R06
      end else if (avs_address == `OFS_THRESHOLD) begin
        next_s.rdata = s.thr & `THR_WMASK;
      end else if (avs_address == `OFS_IRQ_STATUS) begin
        next_s.rdata = {29'h0, s.irq_status};
      end else if (avs_address == `OFS_IRQ_MASK) begin
        next_s.rdata = {29'h0, s.irq_mask};
      end else if (avs_address == `OFS_LINE_STAT) begin
        next_s.rdata = {13'h0, s.c_armed, s.y_armed, fld2, 4'h0, s.line_counter};
      end else if (avs_address == `OFS_CHAN_CFG) begin
        next_s.rdata = {31'h0, s.second_threshold_enable};
      end else begin
        next_s.rdata = 32'h0;
      end
    end else if (req) begin
      next_s.ack = 1'b0;
    end

    // Sticky events; a set in the clearing cycle wins
    next_s.irq_status = s.irq_status |
                        {s.c_event, s.y_event, s.vint_pulse};
    if (avs_write && s.ack) begin
      if (avs_address == `OFS_VINT_CTRL) begin
        next_s.vint_ctrl = merge(s.vint_ctrl, avs_writedata, avs_byteenable,
                                 `VINT_WMASK); // see R05 see R06
      end else if (avs_address == `OFS_THRESHOLD) begin
        next_s.thr = merge(s.thr, avs_writedata, avs_byteenable,
                           `THR_WMASK); // see R06
      end else if (avs_address == `OFS_IRQ_STATUS) begin
        next_s.irq_status = (s.irq_status & ~3'(merge(32'h0, avs_writedata,
                             avs_byteenable, `IRQ_WMASK))) |
                            {s.c_event, s.y_event, s.vint_pulse};
      end else if (avs_address == `OFS_IRQ_MASK) begin
        next_s.irq_mask = 3'(merge({29'h0, s.irq_mask}, avs_writedata,
                                   avs_byteenable, `IRQ_WMASK));
      end else if (avs_address == `OFS_CHAN_CFG) begin
        next_s.second_threshold_enable = merge(32'h0, avs_writedata,
                                               avs_byteenable, `CFG_WMASK) != 32'h0;
      end
    end
    next_s.irq = |(next_s.irq_status & next_s.irq_mask);
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      s <= '0;
      s.vint_ctrl <= `VINT_RESET;
      s.thr <= `THR_RESET;
      s.irq_status <= `IRQ_RESET;
      s.irq_mask <= `IRQ_RESET;
      s.second_threshold_enable <= `CFG_RESET;
      s.y_armed <= 1'b1;
      s.c_armed <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign avs_readdata     = s.rdata;
  assign avs_waitrequest  = req & ~s.ack;
  assign vint_pulse       = s.vint_pulse;
  assign frame_sync_clear = s.sync_clear;
  assign luma_dma_event   = s.y_event;
  assign chroma_dma_event = s.c_event;
  assign irq              = s.irq;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  a_vint_line_match: // see R01
    assert property (s.vint_pulse |-> $past(rise && s.sync2.line_end &&
                     bt_yc && s.line_counter == cur_line))
    else $error("vertical interrupt without a matching line end");
  a_vint_field_enable: // see R02
    assert property ($past(line_hit) && $past(fld2) |->
                     s.vint_pulse == $past(s.vint_ctrl.field2_irq_enable))
    else $error("field 2 interrupt does not follow its enable");
  a_sync_clear_f1: // see R03
    assert property ($past(line_hit && !fld2 &&
                     !s.vint_ctrl.sync_clear_in_second_field) |-> s.sync_clear)
    else $error("frame sync not cleared in field 1");
  a_sync_clear_f2: // see R04
    assert property ($past(line_hit && fld2 &&
                     s.vint_ctrl.sync_clear_in_second_field) |-> s.sync_clear)
    else $error("frame sync not cleared in field 2");
  a_reserved_zero: // see R06
    assert property ((s.vint_ctrl & ~`VINT_WMASK) == 32'h0 &&
                     (s.thr & ~`THR_WMASK) == 32'h0)
    else $error("reserved register bit is set");
  a_mode_gate: // see R07
    assert property (!$past(bt_yc) |-> !s.vint_pulse && !s.sync_clear && !s.c_event)
    else $error("vertical or chroma event outside BT.656 and Y/C");
  a_event_blocked: // see R09
    assert property (!s.y_armed && !dma_first_read |=> !s.y_event)
    else $error("second DMA event before the first FIFO read");
  a_event_armed: // see R08
    assert property (s.y_event |-> !s.y_armed && $past(level) != 14'h0)
    else $error("DMA event with zero threshold or left armed");
  a_vint_single: // see R19
    assert property (s.vint_pulse |=> !s.vint_pulse)
    else $error("vertical interrupt longer than one cycle");
  a_line_reset: // see R18
    assert property ($past(rise && s.sync2.vreset) |-> s.line_counter == 12'h000)
    else $error("line counter not cleared by vertical event");
  a_bus_answer:
    assert property (req && !s.ack |=> !avs_waitrequest || !req)
    else $error("bus access not answered after one wait cycle");
  a_status_sticky: // see R19
    assert property (s.vint_pulse |=> s.irq_status[`IRQ_BIT_VINT])
    else $error("vertical interrupt not latched in status");
  a_line_advance: // see R18
    assert property ($past(rise && !s.sync2.vreset && s.sync2.line_end) |->
                     s.line_counter == $past(s.line_counter) + 12'h001)
    else $error("line counter did not advance at line end");
  a_thr_write: // see R06
    assert property (avs_write && !avs_waitrequest && avs_address == `OFS_THRESHOLD &&
                     avs_byteenable == 4'hf |=> s.thr == ($past(avs_writedata) & `THR_WMASK))
    else $error("threshold write not stored with reserved bits dropped");
endmodule

// ==== testbench/dma_drain_model.sv ====
// Behavioural system DMA controller that drains the capture FIFOs.
// Assumes one-cycle event pulses; answers with a one-cycle first-read strobe.
`timescale 1ns/100ps

module dma_drain_model (
  input  wire logic sys_clk,
  input  wire logic sys_rst,
  input  wire logic luma_dma_event,
  input  wire logic chroma_dma_event,
  input  wire logic stall,
  output logic      dma_first_read
);
  logic       pending;
  logic [1:0] wait_cnt;

  // First FIFO read follows a request after a short wait, or never while stalled
  always_ff @(posedge sys_clk) begin
    dma_first_read <= 1'b0;
    if (sys_rst) begin
      pending  <= 1'b0;
      wait_cnt <= 2'h0;
    end else if (luma_dma_event || chroma_dma_event) begin
      pending  <= 1'b1;
      wait_cnt <= 2'h3;
    end else if (pending && !stall) begin
      if (wait_cnt == 2'h0) begin
        pending        <= 1'b0;
        dma_first_read <= 1'b1;
      end else begin
        wait_cnt <= wait_cnt - 2'h1;
      end
    end
  end
endmodule

// ==== testbench/tb.sv ====
// Self-checking bench of the capture vertical interrupt and DMA threshold block.
// Assumes the DMA drain model and an 80 ns link clock made here.
`timescale 1ns/100ps
`include "capture_vint_consts.svh"
`define CHECK_EQ(got, exp) begin check_count++; if ((got) !== (exp)) begin miscompares++; \
  $display("ERROR %0t: got %0h expected %0h", $time, (got), (exp)); end end

module tb;
  logic                            sys_clk;
  logic                            sys_rst;
  logic [4:0]                      avs_address;
  logic                            avs_read;
  logic                            avs_write;
  logic [31:0]                     avs_writedata;
  logic [3:0]                      avs_byteenable;
  logic [31:0]                     avs_readdata;
  logic                            avs_waitrequest;
  capture_vint_pkg::capture_mode_t cap_mode;
  logic                            raw_16bit;
  capture_vint_pkg::link_t         link;
  logic                            dma_first_read;
  logic                            vint_pulse;
  logic                            frame_sync_clear;
  logic                            luma_dma_event;
  logic                            chroma_dma_event;
  logic                            irq;
  logic                            stall;
  logic [31:0]                     rd_val;
  int                              miscompares = 0;
  int                              check_count = 0;
  int                              n_vint = 0;
  int                              n_sync = 0;
  int                              n_luma = 0;
  int                              n_chroma = 0;

  capture_vint_and_dma_threshold u_capture_vint_and_dma_threshold (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .cap_mode(cap_mode),
    .raw_16bit(raw_16bit), .link(link), .dma_first_read(dma_first_read),
    .vint_pulse(vint_pulse), .frame_sync_clear(frame_sync_clear),
    .luma_dma_event(luma_dma_event), .chroma_dma_event(chroma_dma_event), .irq(irq));

  dma_drain_model u_dma_drain_model (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .luma_dma_event(luma_dma_event),
    .chroma_dma_event(chroma_dma_event), .stall(stall), .dma_first_read(dma_first_read));

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk) begin
    if (vint_pulse === 1'b1) n_vint++;
    if (frame_sync_clear === 1'b1) n_sync++;
    if (luma_dma_event === 1'b1) n_luma++;
    if (chroma_dma_event === 1'b1) n_chroma++;
  end

  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
    avs_address   <= a;
    avs_write     <= wr;
    avs_read      <= !wr;
    avs_writedata <= d;
    do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
    rd_val = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rd(input logic [4:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    `CHECK_EQ(rd_val, exp)
  endtask

  task automatic irq_is(input logic exp);
    repeat (3) @(posedge sys_clk);
    `CHECK_EQ(irq, exp)
  endtask

  // One link clock period: fields change while the link clock is low
  task automatic lk(input logic le, input logic vr, input logic sw, input logic f2);
    link <= '{clk: 1'b0, line_end: le, vreset: vr, sample_wr: sw, field2: f2};
    repeat (4) @(posedge sys_clk);
    link.clk <= 1'b1;
    repeat (4) @(posedge sys_clk);
  endtask

  // Field kept, so the threshold in use does not change while idle
  task automatic settle;
    link <= '{clk: 1'b0, line_end: 1'b0, vreset: 1'b0, sample_wr: 1'b0, field2: link.field2};
    repeat (12) @(posedge sys_clk);
  endtask

  // Vertical event, then lines 0 to 3
  task automatic frame(input logic f2);
    lk(1'b0, 1'b1, 1'b0, f2);
    repeat (4) begin
      lk(1'b1, 1'b0, 1'b0, f2);
      lk(1'b0, 1'b0, 1'b0, f2);
    end
    settle();
  endtask

  task automatic samples(input int n, input logic f2);
    repeat (n) lk(1'b0, 1'b0, 1'b1, f2);
    settle();
  endtask

  task automatic ev(input int v, input int s);
    `CHECK_EQ(n_vint, v)
    `CHECK_EQ(n_sync, s)
  endtask

  task automatic dm(input int y, input int c);
    `CHECK_EQ(n_luma, y)
    `CHECK_EQ(n_chroma, c)
  endtask

  task automatic results;
    $display("comparisons %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  initial begin
    repeat (30000) @(posedge sys_clk);
    miscompares++;
    $display("ERROR %0t: timeout", $time);
    results();
  end

  initial begin
    sys_rst = 1'b1;
    avs_address = 5'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hf;
    cap_mode = capture_vint_pkg::MODE_BT656;
    raw_16bit = 1'b0;
    link = '0;
    stall = 1'b0;
    repeat (16) @(posedge sys_clk);
    sys_rst <= 1'b0;
    @(posedge sys_clk);
    rd(`OFS_VINT_CTRL, 32'h0);
    wr(`OFS_VINT_CTRL, 32'hffffffff);
    rd(`OFS_VINT_CTRL, 32'hcfff8fff);
    wr(`OFS_THRESHOLD, 32'hffffffff);
    rd(`OFS_THRESHOLD, 32'h03ff03ff);
    rd(5'h18, 32'h0);
    $display("test registers done");
    wr(`OFS_VINT_CTRL, 32'h00018002);
    wr(`OFS_IRQ_MASK, 32'h1);
    frame(1'b0);
    ev(1, 1);
    rd(`OFS_LINE_STAT, 32'h00060004);
    irq_is(1'b1);
    frame(1'b1);
    ev(1, 1);
    wr(`OFS_VINT_CTRL, 32'hc0018002);
    frame(1'b1);
    ev(2, 2);
    frame(1'b0);
    ev(3, 2);
    rd(`OFS_IRQ_STATUS, 32'h1);
    wr(`OFS_IRQ_MASK, 32'h0);
    irq_is(1'b0);
    wr(`OFS_IRQ_STATUS, 32'h1);
    wr(`OFS_IRQ_MASK, 32'h1);
    irq_is(1'b0);
    cap_mode <= capture_vint_pkg::MODE_RAW;
    frame(1'b0);
    cap_mode <= capture_vint_pkg::MODE_TRANSPORT;
    frame(1'b0);
    ev(3, 2);
    cap_mode <= capture_vint_pkg::MODE_YC;
    frame(1'b0);
    ev(4, 2);
    $display("test vertical interrupt done");
    cap_mode <= capture_vint_pkg::MODE_BT656;
    stall <= 1'b1;
    wr(`OFS_THRESHOLD, 32'h00000001);
    samples(24, 1'b0);
    dm(1, 1);
    stall <= 1'b0;
    repeat (40) @(posedge sys_clk);
    dm(3, 3);
    wr(`OFS_CHAN_CFG, 32'h1);
    rd(`OFS_CHAN_CFG, 32'h1);
    wr(`OFS_THRESHOLD, 32'h00020001);
    samples(8, 1'b1);
    dm(3, 3);
    samples(8, 1'b1);
    dm(4, 4);
    cap_mode <= capture_vint_pkg::MODE_RAW;
    raw_16bit <= 1'b1;
    samples(4, 1'b1);
    dm(5, 4);
    raw_16bit <= 1'b0;
    samples(4, 1'b0);
    dm(5, 4);
    samples(4, 1'b0);
    dm(6, 4);
    cap_mode <= capture_vint_pkg::MODE_TRANSPORT;
    samples(8, 1'b0);
    dm(7, 4);
    $display("test dma threshold done");
    results();
  end
endmodule
